// File: design/rsts_addr_range.sv
// Inclusive address window detector
`timescale 1ns/10ps
module rsts_addr_range #(
  parameter logic [15:0] LO = 16'h0000,
  parameter logic [15:0] HI = 16'hffff
) (
  // Address in
  input  wire logic [15:0] addr_i,
  // Hit out
  output      logic        hit_o
);

  assign hit_o = (addr_i >= LO) && (addr_i <= HI);

endmodule

// File: design/rsts_pkg.sv
// Constants for the reset-cause capture block
package rsts_pkg;

  // APB register byte offsets
  localparam logic [7:0] OFS_CAUSE_FLAGS = 8'h00;
  localparam logic [7:0] OFS_OPTIONS     = 8'h04;
  localparam logic [7:0] OFS_FORCE_REG   = 8'h08;
  localparam logic [7:0] OFS_LV_CTRL     = 8'h0c;

  // Cause flag bit positions
  localparam int BIT_POWER_ON      = 7;
  localparam int BIT_PIN           = 6;
  localparam int BIT_WATCHDOG      = 5;
  localparam int BIT_BAD_OPCODE    = 4;
  localparam int BIT_BAD_ADDRESS   = 3;
  localparam int BIT_CLOCK_GEN     = 2;
  localparam int BIT_LOW_VOLTAGE   = 1;

  // Options register fields (write-once)
  localparam int BIT_WATCHDOG_EN   = 7;
  localparam int BIT_STOP_EN       = 5;

  // Low-voltage control fields
  localparam int BIT_LV_DETECT_EN  = 1;
  localparam int BIT_LV_RESET_EN   = 0;

  // Reset values
  localparam logic [7:0] RST_CAUSE_FLAGS = 8'h82;
  localparam logic       RST_WATCHDOG_EN = 1'b1;
  localparam logic       RST_STOP_EN     = 1'b0;
  localparam logic       RST_LV_DETECT   = 1'b1;
  localparam logic       RST_LV_RESET    = 1'b1;

  // Illegal address gaps
  localparam logic [15:0] GAP1_LO = 16'h0470;
  localparam logic [15:0] GAP1_HI = 16'h17ff;
  localparam logic [15:0] GAP2_LO = 16'h1860;
  localparam logic [15:0] GAP2_HI = 16'hbfff;

  // Length of the internal reset pulse
  localparam int CLK_PERIOD_PS     = 4000;
  localparam int RESET_HOLD_NS     = 100;
  localparam int RESET_HOLD_CYCLES = (RESET_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [7:0] RESET_HOLD_LOAD = 8'(RESET_HOLD_CYCLES - 1);

  typedef enum logic [0:0] {
    RSTS_RUN,
    RSTS_HOLD
  } rsts_state_type;

endpackage

// File: design/rsts_reset_cause.sv
// Reset-cause capture, reset request and watchdog restart, with APB registers
`timescale 1ns/10ps
module rsts_reset_cause
  import rsts_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        core_clk_i,
  input  wire logic        resetn_i,
  input  wire logic        clk_en_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output      logic [31:0] prdata_o,
  output      logic        pready_o,
  output      logic        pslverr_o,
  // Reset sources
  input  wire logic        ext_reset_n_i,
  input  wire logic        watchdog_timeout_i,
  input  wire logic        clock_gen_reset_i,
  input  wire logic        supply_below_trip_i,
  // Opcode decoder
  input  wire logic        op_valid_i,
  input  wire logic        op_unimplemented_i,
  input  wire logic        op_is_stop_i,
  input  wire logic        op_is_background_i,
  input  wire logic        background_mode_enable_i,
  // CPU access monitor
  input  wire logic        access_valid_i,
  input  wire logic [15:0] access_addr_i,
  // Serial debug write to the force-reset register
  input  wire logic        debug_force_wr_i,
  input  wire logic [7:0]  debug_force_data_i,
  // Results
  output      logic        chip_reset_o,
  output      logic        watchdog_restart_o,
  output      logic        watchdog_enable_o,
  output      logic        stop_mode_enable_o,
  output      logic [7:0]  reset_cause_flags_o
);

  rsts_state_type state;
  logic [7:0]     reset_cause_flags;
  logic [7:0]     hold_count;
  logic           watchdog_enable;
  logic           stop_mode_enable;
  logic           options_written;
  logic           low_voltage_detect_enable;
  logic           low_voltage_reset_enable;
  logic           in_gap_low;
  logic           in_gap_high;
  logic           src_pin;
  logic           src_watchdog;
  logic           src_bad_opcode;
  logic           src_bad_address;
  logic           src_clock_gen;
  logic           src_low_voltage;
  logic           src_debug_force;
  logic           any_source;
  logic [7:0]     next_flags;
  logic           setup_phase;
  logic           access_done;
  logic           addr_mapped;
  logic [31:0]    next_rdata;

  // Only the two documented gaps are checked, so reserved register holes stay legal
  rsts_addr_range #(
    .LO (GAP1_LO),
    .HI (GAP1_HI)
  ) u_gap_low (
    .addr_i (access_addr_i),
    .hit_o  (in_gap_low)
  );

  rsts_addr_range #(
    .LO (GAP2_LO),
    .HI (GAP2_HI)
  ) u_gap_high (
    .addr_i (access_addr_i),
    .hit_o  (in_gap_high)
  );

  // Source qualification
  always_comb
  begin
    src_pin         = !ext_reset_n_i;
    src_watchdog    = watchdog_timeout_i && watchdog_enable;
    src_bad_opcode  = op_valid_i && (op_unimplemented_i
                      || (op_is_stop_i && !stop_mode_enable)
                      || (op_is_background_i && !background_mode_enable_i));
    src_bad_address = access_valid_i && (in_gap_low || in_gap_high);
    src_clock_gen   = clock_gen_reset_i;
    src_low_voltage = supply_below_trip_i && low_voltage_detect_enable
                      && low_voltage_reset_enable;
    src_debug_force = debug_force_wr_i && debug_force_data_i[0];
    any_source      = src_pin || src_watchdog || src_bad_opcode || src_bad_address
                      || src_clock_gen || src_low_voltage || src_debug_force;
  end

  // Flag image captured when a reset is taken
  always_comb
  begin
    next_flags = 8'h00;
    if (src_low_voltage)
    begin
      next_flags[BIT_POWER_ON]    = reset_cause_flags[BIT_POWER_ON];
      next_flags[BIT_LOW_VOLTAGE] = 1'b1;
    end
    else
    begin
      // Debug force contributes no bit of its own
      next_flags[BIT_PIN]         = src_pin;
      next_flags[BIT_WATCHDOG]    = src_watchdog;
      next_flags[BIT_BAD_OPCODE]  = src_bad_opcode;
      next_flags[BIT_BAD_ADDRESS] = src_bad_address;
      next_flags[BIT_CLOCK_GEN]   = src_clock_gen;
    end
  end

  // Reset sequencing
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state      <= RSTS_RUN;
      hold_count <= 8'h00;
    end
    else if (clk_en_i)
    begin
      unique case (state)
        RSTS_RUN:
        begin
          if (any_source)
          begin
            state      <= RSTS_HOLD;
            hold_count <= RESET_HOLD_LOAD;
          end
        end
        RSTS_HOLD:
        begin
          // A pin held low keeps the device in reset
          if (hold_count != 8'h00)
            hold_count <= hold_count - 8'h01;
          else if (ext_reset_n_i)
            state <= RSTS_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      chip_reset_o <= 1'b0;
    else if (clk_en_i)
      chip_reset_o <= (state == RSTS_RUN) ? any_source
                      : ((hold_count != 8'h00) || !ext_reset_n_i);
  end

  // Cause flags; the async reset is the power-on event
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      reset_cause_flags <= RST_CAUSE_FLAGS;
    else if (clk_en_i && state == RSTS_RUN && any_source)
      reset_cause_flags <= next_flags;
  end

  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      reset_cause_flags_o <= RST_CAUSE_FLAGS;
    else if (clk_en_i)
      reset_cause_flags_o <= reset_cause_flags;
  end

  // APB handshake: one wait state, answer in the second access cycle
  assign setup_phase = psel_i && !penable_i;
  assign access_done = psel_i && penable_i && pready_o;
  assign addr_mapped = (paddr_i == OFS_CAUSE_FLAGS) || (paddr_i == OFS_OPTIONS)
                       || (paddr_i == OFS_FORCE_REG) || (paddr_i == OFS_LV_CTRL);

  always_comb
  begin
    next_rdata = 32'h0000_0000;
    unique case (paddr_i)
      OFS_CAUSE_FLAGS: next_rdata[7:0] = {reset_cause_flags[7:1], 1'b0};
      OFS_OPTIONS:
      begin
        next_rdata[BIT_WATCHDOG_EN] = watchdog_enable;
        next_rdata[BIT_STOP_EN]     = stop_mode_enable;
      end
      OFS_LV_CTRL:
      begin
        next_rdata[BIT_LV_DETECT_EN] = low_voltage_detect_enable;
        next_rdata[BIT_LV_RESET_EN]  = low_voltage_reset_enable;
      end
      default:         next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      pready_o  <= 1'b0;
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end
    else if (clk_en_i)
    begin
      pready_o <= psel_i && penable_i && !pready_o;
      if (setup_phase)
      begin
        prdata_o  <= pwrite_i ? 32'h0000_0000 : next_rdata;
        pslverr_o <= !addr_mapped;
      end
    end
  end

  // Watchdog restart pulse; the flags are not touched by the write
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      watchdog_restart_o <= 1'b0;
    else if (clk_en_i)
      watchdog_restart_o <= access_done && pwrite_i && (paddr_i == OFS_CAUSE_FLAGS);
  end

  // Write-once options; an internal reset restores defaults and re-arms the write
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      watchdog_enable  <= RST_WATCHDOG_EN;
      stop_mode_enable <= RST_STOP_EN;
      options_written  <= 1'b0;
    end
    else if (clk_en_i)
    begin
      if (state == RSTS_HOLD)
      begin
        watchdog_enable  <= RST_WATCHDOG_EN;
        stop_mode_enable <= RST_STOP_EN;
        options_written  <= 1'b0;
      end
      else if (access_done && pwrite_i && paddr_i == OFS_OPTIONS && !options_written)
      begin
        watchdog_enable  <= pwdata_i[BIT_WATCHDOG_EN];
        stop_mode_enable <= pwdata_i[BIT_STOP_EN];
        options_written  <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      watchdog_enable_o  <= RST_WATCHDOG_EN;
      stop_mode_enable_o <= RST_STOP_EN;
    end
    else if (clk_en_i)
    begin
      watchdog_enable_o  <= watchdog_enable;
      stop_mode_enable_o <= stop_mode_enable;
    end
  end

  // Low-voltage enables are plain read/write
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      low_voltage_detect_enable <= RST_LV_DETECT;
      low_voltage_reset_enable  <= RST_LV_RESET;
    end
    else if (clk_en_i && access_done && pwrite_i && paddr_i == OFS_LV_CTRL)
    begin
      low_voltage_detect_enable <= pwdata_i[BIT_LV_DETECT_EN];
      low_voltage_reset_enable  <= pwdata_i[BIT_LV_RESET_EN];
    end
  end

endmodule

// File: verif/rsts_reset_cause_assertions.sv
// Assertions for the reset-cause block
`timescale 1ns/10ps
module rsts_reset_cause_checker
  import rsts_pkg::*;
(
  input wire logic        core_clk_i, resetn_i, clk_en_i, psel_i, penable_i, pwrite_i, pready_o,
  input wire logic        ext_reset_n_i, op_valid_i, op_unimplemented_i, access_valid_i,
  input wire logic        chip_reset_o, watchdog_restart_o,
  input wire logic [7:0]  paddr_i, reset_cause_flags_o,
  input wire logic [31:0] prdata_o,
  input wire logic [15:0] access_addr_i
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  logic wr0;
  logic go;
  assign wr0 = psel_i && penable_i && pwrite_i && pready_o && paddr_i == OFS_CAUSE_FLAGS;
  // Sources are only taken while no reset is being held
  assign go = clk_en_i && !chip_reset_o;
  a_bit0_zero: assert property (!reset_cause_flags_o[0] && !(pready_o && paddr_i == OFS_CAUSE_FLAGS && prdata_o[0]))
    else $error("flag bit 0 set");
  a_restart_write: assert property (wr0 |=> watchdog_restart_o)
    else $error("no watchdog restart");
  a_restart_cause: assert property (watchdog_restart_o |-> $past(wr0))
    else $error("stray watchdog restart");
  a_flags_hold: assert property (!chip_reset_o && !$past(chip_reset_o) |-> $stable(reset_cause_flags_o))
    else $error("flags changed without reset");
  a_pin_reset: assert property (go && !ext_reset_n_i |=> chip_reset_o)
    else $error("pin reset missed");
  a_opcode_reset: assert property (go && op_valid_i && op_unimplemented_i |=> chip_reset_o)
    else $error("opcode reset missed");
  a_gap_low: assert property (go && access_valid_i && access_addr_i inside {[GAP1_LO:GAP1_HI]} |=> chip_reset_o)
    else $error("low gap reset missed");
  a_gap_high: assert property (go && access_valid_i && access_addr_i inside {[GAP2_LO:GAP2_HI]} |=> chip_reset_o)
    else $error("high gap reset missed");
  cover property ($rose(chip_reset_o));
  cover property (wr0);
  cover property (go && access_valid_i);
endmodule

// File: verif/test_rsts_reset_cause.sv
// Self-checking bench for the reset-cause block
`timescale 1ns/10ps
module test_rsts_reset_cause;
  import rsts_pkg::*;
  logic        core_clk_i, resetn_i, psel, pen, pwr, bme, er, seen, sme;
  logic [7:0]  paddr, reset_cause_flags_o;
  logic [31:0] pwdata, rd, prdata_o;
  logic [8:0]  src;
  logic [15:0] addr;
  logic        pready_o, pslverr_o, chip_reset_o, watchdog_restart_o, watchdog_enable_o;
  int          error_cnt = 0;
  int          n_compared = 0;
  rsts_reset_cause u_rsts_reset_cause (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i), .clk_en_i(1'b1), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .ext_reset_n_i(!src[0]), .watchdog_timeout_i(src[1]),
    .clock_gen_reset_i(src[2]), .supply_below_trip_i(src[3]), .op_valid_i(|src[6:4]),
    .op_unimplemented_i(src[4]), .op_is_stop_i(src[5]), .op_is_background_i(src[6]),
    .background_mode_enable_i(bme), .access_valid_i(src[7]), .access_addr_i(addr),
    .debug_force_wr_i(src[8]), .debug_force_data_i(8'h01), .chip_reset_o(chip_reset_o),
    .watchdog_restart_o(watchdog_restart_o), .watchdog_enable_o(watchdog_enable_o),
    .stop_mode_enable_o(sme), .reset_cause_flags_o(reset_cause_flags_o));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      error_cnt++;
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk_i);
    pen <= 1'b1;
    // Only the watchdog process ends a wait that never sees pready
    do
      @(posedge core_clk_i);
    while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  // An expectation of ff means no reset may follow
  task automatic cause(input logic [8:0] s, input logic [15:0] a, input logic [7:0] exp);
    int n;
    n = 0;
    @(posedge core_clk_i);
    src <= s;
    addr <= a;
    @(posedge core_clk_i);
    src <= 9'h000;
    #1 chk({31'h0, chip_reset_o}, {31'h0, exp != 8'hff});
    while (chip_reset_o !== 1'b0 && n < 100)
    begin
      @(posedge core_clk_i);
      n++;
    end
    repeat (3) @(posedge core_clk_i);
    if (exp != 8'hff)
      chk({24'h0, reset_cause_flags_o}, {24'h0, exp});
  endtask
  task automatic t_por();
    #1 chk({24'h0, reset_cause_flags_o}, 32'h82);
    apb(1'b0, OFS_CAUSE_FLAGS, 32'h0);
    chk(rd, 32'h82);
    chk({31'h0, watchdog_enable_o}, 32'h1);
    apb(1'b0, 8'h10, 32'h0);
    chk({31'h0, er}, 32'h1);
  endtask
  task automatic t_restart();
    seen = 1'b0;
    apb(1'b1, OFS_CAUSE_FLAGS, 32'hffffffff);
    repeat (3)
    begin
      #1 seen = seen | watchdog_restart_o;
      @(posedge core_clk_i);
    end
    chk({31'h0, seen}, 32'h1);
    apb(1'b0, OFS_CAUSE_FLAGS, 32'h0);
    chk(rd, 32'h82);
  endtask
  task automatic t_sources();
    cause(9'h008, 16'h0, 8'h82);
    cause(9'h001, 16'h0, 8'h40);
    cause(9'h008, 16'h0, 8'h02);
    cause(9'h004, 16'h0, 8'h04);
    cause(9'h005, 16'h0, 8'h44);
    cause(9'h010, 16'h0, 8'h10);
    cause(9'h020, 16'h0, 8'h10);
    cause(9'h040, 16'h0, 8'h10);
    cause(9'h080, 16'h0470, 8'h08);
    cause(9'h080, 16'h17ff, 8'h08);
    cause(9'h080, 16'h1860, 8'h08);
    cause(9'h080, 16'hbfff, 8'h08);
    cause(9'h100, 16'h0, 8'h00);
    cause(9'h002, 16'h0, 8'h20);
  endtask
  task automatic t_quiet();
    bme <= 1'b1;
    cause(9'h040, 16'h0, 8'hff);
    cause(9'h080, 16'h046f, 8'hff);
    cause(9'h080, 16'h1800, 8'hff);
    cause(9'h080, 16'hc000, 8'hff);
    apb(1'b1, OFS_FORCE_REG, 32'h1);
    #1 chk({31'h0, chip_reset_o}, 32'h0);
  endtask
  task automatic t_wdog();
    // The enable outputs trail the internal options by one cycle
    apb(1'b1, OFS_OPTIONS, 32'h0);
    @(posedge core_clk_i);
    #1 chk({31'h0, watchdog_enable_o}, 32'h0);
    apb(1'b1, OFS_OPTIONS, 32'ha0);
    @(posedge core_clk_i);
    #1 chk({31'h0, watchdog_enable_o}, 32'h0);
    chk({31'h0, sme}, 32'h0);
    cause(9'h002, 16'h0, 8'hff);
    cause(9'h020, 16'h0, 8'h10);
    chk({31'h0, watchdog_enable_o}, 32'h1);
    apb(1'b1, OFS_OPTIONS, 32'h20);
    @(posedge core_clk_i);
    #1 chk({31'h0, sme}, 32'h1);
    cause(9'h020, 16'h0, 8'hff);
  endtask
  // Power-on again in mid-run, after the flags hold another cause
  task automatic t_rst();
    @(posedge core_clk_i);
    resetn_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    #1 chk({24'h0, reset_cause_flags_o}, 32'h82);
    chk({31'h0, watchdog_enable_o}, 32'h1);
    apb(1'b0, OFS_CAUSE_FLAGS, 32'h0);
    chk(rd, 32'h82);
  endtask
  task automatic final_report();
    if (error_cnt == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end
  // Whole run needs about 560 cycles
  initial
  begin
    #40000;
    error_cnt++;
    final_report();
  end
  initial
  begin
    resetn_i = 1'b0;
    {psel, pen, pwr, bme, paddr, pwdata, src, addr} = '0;
    repeat (20) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    t_por();
    t_restart();
    t_sources();
    t_quiet();
    t_wdog();
    t_rst();
    final_report();
  end
endmodule
bind rsts_reset_cause rsts_reset_cause_checker u_rsts_reset_cause_checker (
  .core_clk_i(core_clk_i), .resetn_i(resetn_i), .clk_en_i(clk_en_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .pready_o(pready_o), .ext_reset_n_i(ext_reset_n_i), .op_valid_i(op_valid_i),
  .op_unimplemented_i(op_unimplemented_i), .access_valid_i(access_valid_i), .chip_reset_o(chip_reset_o),
  .watchdog_restart_o(watchdog_restart_o), .paddr_i(paddr_i), .reset_cause_flags_o(reset_cause_flags_o),
  .prdata_o(prdata_o), .access_addr_i(access_addr_i));
